// >>> inc/smi_consts.vh
/*
 * Constants of the stepper microstep indexer: timing figures, index
 * geometry, reset positions and encodings of modes and decay methods.
 * Assumes a 100 MHz core clock; counts are worked out for 10 ns.
 */
`ifndef SMI_CONSTS_VH
`define SMI_CONSTS_VH

// core clock
`define SMI_CLK_PERIOD_NS 10

// short protection retry wait, in microseconds, and its cycle count;
// counts are sized to their counters so no bits drop at the parameter
`define SMI_SHORT_LATCH_US 256
`define SMI_SHORT_LATCH_CYC 15'h6400

// window after the retry in which a persisting short latches standby
`define SMI_RETRY_CHECK_NS 1000
`define SMI_RETRY_CHECK_CYC 15'h0064

// idle indicator timeout, in milliseconds, and its cycle count
`define SMI_IDLE_MS 600
`define SMI_IDLE_CYC 26'h3938700

// index geometry: 128 fine steps per quarter, 512 per electrical cycle
`define SMI_INDEX_W 9
`define SMI_MAG_W 7
`define SMI_QUARTER 8'h80
`define SMI_FULL_MAG 7'h64

// reset positions
`define SMI_RESET_POS_MICRO 9'h000
`define SMI_RESET_POS_TWO 9'h1C0

// excitation modes, code = {bit2, bit1, bit0}
`define SMI_MODE_TWO 3'h0
`define SMI_MODE_HALF 3'h1
`define SMI_MODE_FINEST 3'h7

// decay methods
`define SMI_DECAY_SLOW 2'h0
`define SMI_DECAY_MIXED 2'h1
`define SMI_DECAY_FAST 2'h2

`endif

// >>> src/smi_cos_table.v
/*
 * Quarter-wave current ratio table of the indexer, in percent.
 * Assumes the caller folds the electrical angle into 0..128.
 */
`timescale 1ns/1ps
`include "smi_consts.vh"

module smi_cos_table (
	// folded angle, 0 is full current, 128 is zero
	input wire [7:0] angle_idx,
	// current ratio in percent
	output wire [`SMI_MAG_W-1:0] ratio
);

	// entry k sits at bits [7k +: 7], listed from entry 128 down to 0
	localparam [902:0] TBL = {
		7'h00, 7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h09,
		7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0F, 7'h10, 7'h11, 7'h12,
		7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1B, 7'h1C,
		7'h1D, 7'h1E, 7'h1F, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
		7'h26, 7'h27, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E,
		7'h2F, 7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h37,
		7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3E,
		7'h3F, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
		7'h47, 7'h48, 7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4C, 7'h4D,
		7'h4D, 7'h4E, 7'h4F, 7'h50, 7'h50, 7'h51, 7'h52, 7'h52,
		7'h53, 7'h54, 7'h54, 7'h55, 7'h56, 7'h56, 7'h57, 7'h58,
		7'h58, 7'h59, 7'h59, 7'h5A, 7'h5A, 7'h5B, 7'h5B, 7'h5C,
		7'h5C, 7'h5D, 7'h5D, 7'h5E, 7'h5E, 7'h5F, 7'h5F, 7'h5F,
		7'h60, 7'h60, 7'h60, 7'h61, 7'h61, 7'h61, 7'h62, 7'h62,
		7'h62, 7'h62, 7'h63, 7'h63, 7'h63, 7'h63, 7'h63, 7'h63,
		7'h64, 7'h64, 7'h64, 7'h64, 7'h64, 7'h64, 7'h64, 7'h64,
		7'h64
	};

	// out-of-range angles never occur; the caller folds to 0..128
	assign ratio = TBL[angle_idx * 7 +: 7];

endmodule // smi_cos_table

// >>> src/smi_indexer.v
/*
 * Step/direction indexer of a two-phase bipolar stepper driver: mode
 * decode, phase-current index, standby, output enable, decay select,
 * short-circuit retry and latch, and the open-drain idle indicator.
 * Assumes all pin inputs are asynchronous to clk and that the analog
 * bridge, comparators and current chopper sit outside this block.
 */
`timescale 1ns/1ps
`include "smi_consts.vh"

module smi_indexer #(
	parameter [14:0] SHORT_LATCH_CYCLES = `SMI_SHORT_LATCH_CYC,
	parameter [25:0] IDLE_CYCLES = `SMI_IDLE_CYC
) (
	// clock, reset, enable
	input wire clk,
	input wire sys_rst,
	input wire clk_en,
	// host pins
	input wire chip_enable,
	input wire step_in,
	input wire rotation_direction_input,
	input wire output_enable,
	input wire excitation_select_bit0,
	input wire excitation_select_bit1,
	input wire excitation_select_bit2,
	// decay select comparators: above high level, below low level
	input wire decay_select_input_high,
	input wire decay_select_input_low,
	// bridge short comparator
	input wire short_detect,
	// phase currents to the bridge
	output reg [`SMI_MAG_W-1:0] phase_a_ratio,
	output reg phase_a_negative,
	output reg [`SMI_MAG_W-1:0] phase_b_ratio,
	output reg phase_b_negative,
	output reg bridge_drive,
	output reg [1:0] decay_mode,
	// status
	output reg [2:0] excitation_mode,
	output reg [`SMI_INDEX_W-1:0] step_index,
	output reg standby,
	output reg short_latched,
	// open-drain idle indicator
	input wire idle_od_in,
	output wire idle_od_o,
	output reg idle_od_oe
);

	localparam [1:0] PRT_RUN = 2'h0;
	localparam [1:0] PRT_OFF = 2'h1;
	localparam [1:0] PRT_RETRY = 2'h2;
	localparam [1:0] PRT_LATCH = 2'h3;
	localparam [14:0] RETRY_CHECK_CYCLES = `SMI_RETRY_CHECK_CYC;

	// index increment for a mode: 1 for finest up to 128 for two-phase
	function [`SMI_INDEX_W-1:0] step_size;
		input [2:0] mode;
		begin
			step_size = 9'h080 >> mode;
		end
	endfunction

	// reset position of a mode
	function [`SMI_INDEX_W-1:0] reset_pos;
		input [2:0] mode;
		begin
			if (mode == `SMI_MODE_TWO) begin
				reset_pos = `SMI_RESET_POS_TWO;
			end else begin
				reset_pos = `SMI_RESET_POS_MICRO;
			end
		end
	endfunction

	// fold a quarter offset into the table range, mirrored or not
	function [7:0] fold;
		input [6:0] offs;
		input mirror;
		begin
			if (mirror) begin
				fold = `SMI_QUARTER - {1'b0, offs};
			end else begin
				fold = {1'b0, offs};
			end
		end
	endfunction

	// pin synchronisers
	reg [9:0] pin_meta;
	reg [9:0] pin_sync;
	wire [9:0] pin_raw;
	assign pin_raw = {chip_enable, step_in, rotation_direction_input,
		output_enable, excitation_select_bit2, excitation_select_bit1,
		excitation_select_bit0, decay_select_input_high,
		decay_select_input_low, short_detect};

	wire ce_s;
	wire step_s;
	wire dir_s;
	wire oe_s;
	wire [2:0] mode_s;
	wire dec_hi_s;
	wire dec_lo_s;
	wire short_s;
	assign ce_s = pin_sync[9];
	assign step_s = pin_sync[8];
	assign dir_s = pin_sync[7];
	assign oe_s = pin_sync[6];
	assign mode_s = pin_sync[5:3];
	assign dec_hi_s = pin_sync[2];
	assign dec_lo_s = pin_sync[1];
	assign short_s = pin_sync[0];

	reg step_prev;
	wire step_rise;
	assign step_rise = step_s & ~step_prev;

	// protection and idle state
	reg [1:0] prt_state;
	reg [1:0] next_prt_state;
	reg [14:0] prt_cnt;
	reg [14:0] next_prt_cnt;
	reg [25:0] idle_cnt;

	// the open-drain pin only ever pulls low
	assign idle_od_o = 1'b0;

	// standby: chip enable low or the short latch holds the device off
	wire standby_now;
	assign standby_now = ~ce_s | (prt_state == PRT_LATCH);

	// index update
	reg [`SMI_INDEX_W-1:0] next_step_index;
	always @* begin
		next_step_index = step_index;
		if (standby_now) begin
			next_step_index = reset_pos(mode_s);
		end else if (step_rise) begin
			// direction taken at the edge itself; 9-bit math wraps
			if (dir_s) begin
				next_step_index = step_index + step_size(mode_s);
			end else begin
				next_step_index = step_index - step_size(mode_s);
			end
		end
		// no edge: position held
	end

	// phase A follows cos, phase B follows sin of the index angle;
	// rising angle makes B lag A, falling angle makes B lead A
	wire [1:0] quad;
	wire [6:0] offs;
	assign quad = next_step_index[8:7];
	assign offs = next_step_index[6:0];

	wire [7:0] a_angle;
	wire [7:0] b_angle;
	assign a_angle = fold(offs, quad[0]);
	assign b_angle = fold(offs, ~quad[0]);

	wire [`SMI_MAG_W-1:0] a_tbl;
	wire [`SMI_MAG_W-1:0] b_tbl;

	// coarse modes land only on evenly spaced table entries
	smi_cos_table u_tbl_a (
		.angle_idx(a_angle),
		.ratio(a_tbl)
	);

	smi_cos_table u_tbl_b (
		.angle_idx(b_angle),
		.ratio(b_tbl)
	);

	reg [`SMI_MAG_W-1:0] next_a_ratio;
	reg [`SMI_MAG_W-1:0] next_b_ratio;
	reg next_a_neg;
	reg next_b_neg;
	always @* begin
		next_a_neg = quad[1] ^ quad[0];
		next_b_neg = quad[1];
		if (mode_s == `SMI_MODE_TWO) begin
			// two-phase sits at 45 degree points and drives full current
			next_a_ratio = `SMI_FULL_MAG;
			next_b_ratio = `SMI_FULL_MAG;
		end else begin
			next_a_ratio = a_tbl;
			next_b_ratio = b_tbl;
		end
		// no sign on a zero current
		if (next_a_ratio == 7'h00) begin
			next_a_neg = 1'b0;
		end
		if (next_b_ratio == 7'h00) begin
			next_b_neg = 1'b0;
		end
	end

	// short protection sequencer
	always @* begin
		next_prt_state = prt_state;
		next_prt_cnt = prt_cnt;
		case (prt_state)
		PRT_RUN: begin
			next_prt_cnt = 15'h0000;
			if (bridge_drive && short_s) begin
				next_prt_state = PRT_OFF;
			end
		end
		PRT_OFF: begin
			if (prt_cnt == SHORT_LATCH_CYCLES - 15'h0001) begin
				next_prt_state = PRT_RETRY;
				next_prt_cnt = 15'h0000;
			end else begin
				next_prt_cnt = prt_cnt + 15'h0001;
			end
		end
		PRT_RETRY: begin
			// the comparator is only trusted once the bridge drives again
			if (bridge_drive && short_s) begin
				next_prt_state = PRT_LATCH;
			end else if (prt_cnt == RETRY_CHECK_CYCLES - 15'h0001) begin
				next_prt_state = PRT_RUN;
			end else begin
				next_prt_cnt = prt_cnt + 15'h0001;
			end
		end
		PRT_LATCH: begin
			// held until chip enable drops, see the clocked process
			next_prt_state = PRT_LATCH;
		end
		default: begin
			next_prt_state = PRT_RUN;
			next_prt_cnt = 15'h0000;
		end
		endcase
	end

	// decay decode; high wins should both comparators ever agree
	reg [1:0] next_decay_mode;
	always @* begin
		if (dec_hi_s) begin
			next_decay_mode = `SMI_DECAY_SLOW;
		end else if (dec_lo_s) begin
			next_decay_mode = `SMI_DECAY_FAST;
		end else begin
			next_decay_mode = `SMI_DECAY_MIXED;
		end
	end

	// bridges run only outside standby, with enable, and not in retry wait
	wire next_drive;
	assign next_drive = ~standby_now & oe_s &
		(next_prt_state == PRT_RUN || next_prt_state == PRT_RETRY);

	// synchronisers: second stage alone feeds logic
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_meta <= 10'h000;
			pin_sync <= 10'h000;
			step_prev <= 1'b0;
		end else if (clk_en) begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			step_prev <= step_s;
		end
	end

	// index, currents and status
	always @(posedge clk) begin
		if (sys_rst) begin
			step_index <= `SMI_RESET_POS_MICRO;
			phase_a_ratio <= 7'h00;
			phase_a_negative <= 1'b0;
			phase_b_ratio <= 7'h00;
			phase_b_negative <= 1'b0;
			bridge_drive <= 1'b0;
			decay_mode <= `SMI_DECAY_MIXED;
			excitation_mode <= `SMI_MODE_TWO;
			standby <= 1'b1;
		end else if (clk_en) begin
			step_index <= next_step_index;
			// currents track the index even while disabled
			phase_a_ratio <= next_a_ratio;
			phase_a_negative <= next_a_neg;
			phase_b_ratio <= next_b_ratio;
			phase_b_negative <= next_b_neg;
			bridge_drive <= next_drive;
			decay_mode <= next_decay_mode;
			excitation_mode <= mode_s;
			standby <= standby_now;
		end
	end

	// protection state; chip enable low is the only way out of latch
	always @(posedge clk) begin
		if (sys_rst) begin
			prt_state <= PRT_RUN;
			prt_cnt <= 15'h0000;
			short_latched <= 1'b0;
		end else if (clk_en) begin
			if (!ce_s) begin
				prt_state <= PRT_RUN;
				prt_cnt <= 15'h0000;
				short_latched <= 1'b0;
			end else begin
				prt_state <= next_prt_state;
				prt_cnt <= next_prt_cnt;
				short_latched <= (next_prt_state == PRT_LATCH);
			end
		end
	end

	// idle timer; saturates once the indicator is pulled
	always @(posedge clk) begin
		if (sys_rst) begin
			idle_cnt <= 26'h0000000;
			idle_od_oe <= 1'b0;
		end else if (clk_en) begin
			if (standby_now || step_rise) begin
				idle_cnt <= 26'h0000000;
				idle_od_oe <= 1'b0;
			end else if (!idle_od_oe) begin
				if (idle_cnt == IDLE_CYCLES - 26'h0000001) begin
					idle_od_oe <= 1'b1;
				end else begin
					idle_cnt <= idle_cnt + 26'h0000001;
				end
			end
		end
	end

	// the pin read-back is not needed by this block
	wire unused_idle_in;
	assign unused_idle_in = idle_od_in;

endmodule // smi_indexer

// >>> tb/smi_props.sv
/*
 * Assertion checker for smi_indexer, bound after the module.
 * Assumes one 100 MHz clock, a synchronous active-high reset and the
 * two-flop pin synchronisers, so pins show at the outputs 3 edges later.
 */
`timescale 1ns/1ps
`include "smi_consts.vh"

module smi_props #(
	parameter [25:0] IDLE_CYCLES = 26'h0000032
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	input wire clk_en,
	// pins
	input wire chip_enable,
	input wire step_in,
	input wire rotation_direction_input,
	input wire output_enable,
	input wire decay_select_input_high,
	input wire decay_select_input_low,
	input wire short_detect,
	// outputs
	input wire bridge_drive,
	input wire [1:0] decay_mode,
	input wire [2:0] excitation_mode,
	input wire [8:0] step_index,
	input wire standby,
	input wire short_latched,
	input wire idle_od_oe
);
	reg [7:0] quiet;
	reg step_d;

	function [1:0] dexp(input h, input l);
		dexp = h ? `SMI_DECAY_SLOW : (l ? `SMI_DECAY_FAST : `SMI_DECAY_MIXED);
	endfunction

	// saturates so a long quiet spell cannot wrap back to zero
	always @(posedge clk) begin
		step_d <= step_in;
		// frozen core does not count, so the spell restarts on resume
		if (sys_rst || !clk_en || standby || (step_in && !step_d))
			quiet <= 8'h00;
		else if (quiet != 8'hFF)
			quiet <= quiet + 8'h01;
	end

	default clocking cb @(posedge clk); endclocking
	// pin to output latencies only hold while the core is clocked
	default disable iff (sys_rst || !clk_en);

	a_standby_ce_low: assert property (
		!chip_enable [*3] |=> standby && !bridge_drive)
		else $error("no standby while chip enable low");
	a_reset_position: assert property (
		$fell(standby) |-> step_index ==
		(excitation_mode == `SMI_MODE_TWO ? 9'h1C0 : 9'h000))
		else $error("leaving standby off the reset position");
	a_step_moves: assert property (
		$rose(step_in) && chip_enable && !standby |-> ##3
		step_index == $past(step_index) + ($past(rotation_direction_input, 3)
		? (9'h080 >> excitation_mode) : -(9'h080 >> excitation_mode)))
		else $error("step did not move the index by one position");
	a_index_hold: assert property (
		(!step_in && chip_enable && !short_detect) [*5] |=> $stable(step_index))
		else $error("index moved without a step");
	a_oe_off: assert property (
		!output_enable [*3] |=> !bridge_drive)
		else $error("bridge on while output enable low");
	a_decay_decode: assert property (
		($stable(decay_select_input_high) && $stable(decay_select_input_low))
		[*3] |=> decay_mode == dexp($past(decay_select_input_high),
		$past(decay_select_input_low)))
		else $error("decay mode mismatch");
	a_short_cuts: assert property (
		(short_detect && bridge_drive) [*3] |=> !bridge_drive)
		else $error("bridge stayed on into a short");
	a_latch_holds: assert property (
		chip_enable [*3] ##0 short_latched |=> short_latched)
		else $error("short latch released without chip enable low");
	a_idle_sets: assert property (
		quiet > IDLE_CYCLES + 8 |-> idle_od_oe)
		else $error("idle indicator not pulled after quiet spell");
	a_idle_clears: assert property (
		idle_od_oe && $rose(step_in) && !standby |-> ##3 !idle_od_oe)
		else $error("idle indicator not released by step");

	c_step: cover property ($rose(step_in) && !standby);
	c_latch: cover property ($rose(short_latched));
	c_idle: cover property ($rose(idle_od_oe));
endmodule // smi_props

bind smi_indexer smi_props #(.IDLE_CYCLES(IDLE_CYCLES)) smi_props_i (
	.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.chip_enable(chip_enable),
	.step_in(step_in), .rotation_direction_input(rotation_direction_input),
	.output_enable(output_enable), .short_detect(short_detect),
	.decay_select_input_high(decay_select_input_high),
	.decay_select_input_low(decay_select_input_low),
	.bridge_drive(bridge_drive), .decay_mode(decay_mode),
	.excitation_mode(excitation_mode), .step_index(step_index),
	.standby(standby), .short_latched(short_latched),
	.idle_od_oe(idle_od_oe));

// >>> tb/smi_host_model.sv
/*
 * Host step/direction controller model driving the indexer pins.
 * Assumes the bench calls its tasks; pins change on falling edges only.
 */
`timescale 1ns/1ps

module smi_host_model (
	// clock
	input wire clk,
	// pins to the indexer
	output logic chip_enable,
	output logic step_in,
	output logic rotation_direction_input
);
	initial begin
		chip_enable = 1'b0;
		step_in = 1'b0;
		rotation_direction_input = 1'b1;
	end

	// direction settles before the rise; gap lets the host run slow
	task step(input logic dir, input logic [2:0] gap);
		@(negedge clk);
		rotation_direction_input = dir;
		repeat (2) @(negedge clk);
		step_in = 1'b1;
		repeat (3) @(negedge clk);
		step_in = 1'b0;
		repeat (3 + gap) @(negedge clk);
	endtask

	// standby entry is also the only way out of a short latch
	task set_ce(input logic v);
		@(negedge clk);
		chip_enable = v;
		repeat (5) @(negedge clk);
	endtask
endmodule // smi_host_model

// >>> tb/tb_top.sv
/*
 * Self-checking bench for smi_indexer with the host model on the pins.
 * Assumes short counts for retry and idle timers to keep the run brief.
 */
`timescale 1ns/1ps
`include "smi_consts.vh"

module tb_top;
	localparam [14:0] SHORT_CYC = 15'h0014;
	localparam [25:0] IDLE_CYC = 26'h0000032;
	logic clk, sys_rst, clk_en, output_enable, dec_hi, dec_lo;
	logic short_detect, seen;
	logic [2:0] mode_sel;
	logic [31:0] seed;
	logic [8:0] exp_idx;
	int n_fail, checks_done;
	wire chip_enable, step_in, dir, pa_n, pb_n, bridge_drive, standby;
	wire short_latched, idle_od_o, idle_od_oe;
	wire [6:0] pa, pb;
	wire [1:0] decay_mode;
	wire [2:0] excitation_mode;
	wire [8:0] step_index;
	// pulled-up open-drain pin
	wire idle_pin = idle_od_oe ? idle_od_o : 1'b1;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	smi_host_model smi_host_model_i (.clk(clk), .chip_enable(chip_enable),
		.step_in(step_in), .rotation_direction_input(dir));

	smi_indexer #(.SHORT_LATCH_CYCLES(SHORT_CYC), .IDLE_CYCLES(IDLE_CYC))
	smi_indexer_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.chip_enable(chip_enable), .step_in(step_in),
		.rotation_direction_input(dir), .output_enable(output_enable),
		.excitation_select_bit0(mode_sel[0]),
		.excitation_select_bit1(mode_sel[1]),
		.excitation_select_bit2(mode_sel[2]),
		.decay_select_input_high(dec_hi), .decay_select_input_low(dec_lo),
		.short_detect(short_detect), .phase_a_ratio(pa),
		.phase_a_negative(pa_n), .phase_b_ratio(pb), .phase_b_negative(pb_n),
		.bridge_drive(bridge_drive), .decay_mode(decay_mode),
		.excitation_mode(excitation_mode), .step_index(step_index),
		.standby(standby), .short_latched(short_latched),
		.idle_od_in(idle_pin), .idle_od_o(idle_od_o), .idle_od_oe(idle_od_oe));

	function automatic [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic [8:0] nxt(input [8:0] i, input [2:0] m, input d);
		nxt = d ? i + (9'h080 >> m) : i - (9'h080 >> m);
	endfunction

	// B current one mode step behind the reset position, negative
	function automatic [8:0] first_b(input int m);
		first_b = m == 7 ? 9'h101 : m == 6 ? 9'h102 :
			m == 5 ? 9'h105 : 9'h10A;
	endfunction

	function automatic [8:0] rpos(input [2:0] m);
		rpos = m == 3'h0 ? `SMI_RESET_POS_TWO : `SMI_RESET_POS_MICRO;
	endfunction

	task check(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task cycle_ce;
		smi_host_model_i.set_ce(1'b0);
		smi_host_model_i.set_ce(1'b1);
	endtask

	initial begin
		#100000;
		n_fail++;
		$display("ERROR t=%0t run hung", $time);
		complete_run;
	end

	initial begin
		{sys_rst, clk_en, output_enable, dec_hi, dec_lo, short_detect} = 6'h38;
		{n_fail, checks_done, mode_sel, seen} = 0;
		seed = 32'h71F86945;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		for (int m = 0; m < 8; m++) begin
			mode_sel = m[2:0];
			cycle_ce;
			check({6'h00, excitation_mode}, {6'h00, m[2:0]});
			check(step_index, rpos(m[2:0]));
			check({pa_n, 1'b0, pa}, 9'h064);
			check({pb_n, 1'b0, pb}, m == 0 ? 9'h164 : 9'h000);
			exp_idx = rpos(m[2:0]);
			for (int k = 0; k < 6; k++) begin
				seed = lfsr(seed);
				seed[0] = seed[0] && k != 0;
				smi_host_model_i.step(seed[0], seed[3:1]);
				exp_idx = nxt(exp_idx, m[2:0], seed[0]);
				check(step_index, exp_idx);
				if (k == 0 && m > 3)
					check({pb_n, 1'b0, pb}, first_b(m));
			end
			repeat (20) @(negedge clk);
			check(step_index, exp_idx);
		end
		$display("mode and step test done");
		mode_sel = 3'h1;
		cycle_ce;
		repeat (2) smi_host_model_i.step(1'b1, 3'h0);
		check({pa_n, 1'b0, pa}, 9'h000);
		check({pb_n, 1'b0, pb}, 9'h064);
		repeat (4) smi_host_model_i.step(1'b0, 3'h1);
		check({pb_n, 1'b0, pb}, 9'h164);
		output_enable = 1'b0;
		repeat (2) smi_host_model_i.step(1'b0, 3'h0);
		check({8'h00, bridge_drive}, 9'h000);
		check(step_index, 9'h100);
		output_enable = 1'b1;
		repeat (4) @(negedge clk);
		check({7'h00, bridge_drive, pa_n}, 9'h003);
		$display("direction and enable test done");
		for (int d = 0; d < 3; d++) begin
			{dec_hi, dec_lo} = d == 0 ? 2'h2 : {1'b0, d == 2};
			repeat (4) @(negedge clk);
			check({7'h00, decay_mode}, {7'h00, d[1:0]});
		end
		repeat (70) @(negedge clk);
		check({7'h00, idle_pin, idle_od_oe}, 9'h001);
		smi_host_model_i.step(1'b1, 3'h0);
		check({7'h00, idle_pin, idle_od_oe}, 9'h002);
		$display("decay and idle test done");
		// a step pulse wholly inside a freeze is never seen
		clk_en = 1'b0;
		smi_host_model_i.step(1'b1, 3'h0);
		check(step_index, 9'h140);
		clk_en = 1'b1;
		repeat (4) @(negedge clk);
		check(step_index, 9'h140);
		$display("clock enable test done");
		short_detect = 1'b1;
		repeat (5) @(negedge clk);
		check({7'h00, bridge_drive, short_latched}, 9'h000);
		repeat (SHORT_CYC + 10) begin
			@(negedge clk);
			seen = seen | bridge_drive;
		end
		check({8'h00, seen}, 9'h001);
		check({7'h00, short_latched, standby}, 9'h003);
		short_detect = 1'b0;
		smi_host_model_i.step(1'b1, 3'h0);
		check(step_index, rpos(3'h1));
		check({8'h00, short_latched}, 9'h001);
		cycle_ce;
		check({7'h00, short_latched, standby}, 9'h000);
		$display("short test done");
		complete_run;
	end
endmodule // tb_top
